/* File: core/tsr_pkg.sv */
// Constants, register map and carrier types for the two-wire receive engine.
// Assumes a 200 MHz system clock and an APB master with 32-bit data.
package tsr_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_DATA = 8'h08;
   localparam logic [7:0] OFS_ADDR = 8'h0c;

   // Control register fields
   localparam int CB_IRQ = 7;
   localparam int CB_ACK = 6;
   localparam int CB_STA = 5;
   localparam int CB_STO = 4;
   localparam int CB_WC  = 3;
   localparam int CB_EN  = 2;
   localparam int CB_IE  = 0;

   // Status register fields
   localparam int SB_CODE_LSB = 3;
   localparam int SB_PRE_MSB  = 1;

   // Reset values
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_STAT = 8'hf8;
   localparam logic [7:0] RST_DATA = 8'hff;
   localparam logic [7:0] RST_ADDR = 8'hfe;

   // Status codes
   localparam logic [7:0] SC_START   = 8'h08;
   localparam logic [7:0] SC_RSTART  = 8'h10;
   localparam logic [7:0] SC_AW_ACK  = 8'h18;
   localparam logic [7:0] SC_AW_NACK = 8'h20;
   localparam logic [7:0] SC_DT_ACK  = 8'h28;
   localparam logic [7:0] SC_DT_NACK = 8'h30;
   localparam logic [7:0] SC_ARB     = 8'h38;
   localparam logic [7:0] SC_AR_ACK  = 8'h40;
   localparam logic [7:0] SC_AR_NACK = 8'h48;
   localparam logic [7:0] SC_MR_ACK  = 8'h50;
   localparam logic [7:0] SC_MR_NACK = 8'h58;
   localparam logic [7:0] SC_SW_OWN  = 8'h60;
   localparam logic [7:0] SC_SW_ARB  = 8'h68;
   localparam logic [7:0] SC_GC      = 8'h70;
   localparam logic [7:0] SC_GC_ARB  = 8'h78;
   localparam logic [7:0] SC_SD_ACK  = 8'h80;
   localparam logic [7:0] SC_SD_NACK = 8'h88;
   localparam logic [7:0] SC_GD_ACK  = 8'h90;
   localparam logic [7:0] SC_GD_NACK = 8'h98;
   localparam logic [7:0] SC_SR_OWN  = 8'ha8;
   localparam logic [7:0] SC_SR_ARB  = 8'hb0;

   // Bus timing
   localparam int SCL_LOW_NS  = 4700;
   localparam int SCL_HIGH_NS = 4000;
   localparam int CLK_MHZ     = 200;
   localparam logic [9:0] LOW_CYC  = 10'((SCL_LOW_NS * CLK_MHZ + 999) / 1000);
   localparam logic [9:0] HIGH_CYC = 10'((SCL_HIGH_NS * CLK_MHZ + 999) / 1000);

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } tsr_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } tsr_apb_rsp_t;

   typedef enum {ST_IDLE, ST_START, ST_BIT, ST_STOP, ST_HOLD} tsr_state_t;

endpackage : tsr_pkg

/* File: core/tsr_core.sv */
// Two-wire bus master receiver / slave receiver with APB registers.
// Assumes open-drain pads resolved outside; SCL_I and SDA_I are asynchronous.
// Notes on behaviour
// - After START code 0x08, software loads read address, clears flag; address goes out.
// - After repeated START 0x10, read address continues receive, write address transmits.
// - Arbitration lost 0x38: no start releases bus; start retries once bus free.
// - Code 0x40: next byte received, acked per acknowledge enable.
// - Code 0x48: repeated START, STOP, or STOP then START; stop request self-clears.
// - Code 0x50: software reads data; next byte acked per acknowledge enable.
// - Code 0x58: after read, repeated START, STOP or STOP then START.
// - Own-address register upper seven bits hold the slave address answered.
// - Address register bit zero enables answering the general call address.
// - Direction bit zero after match means slave receive, one slave transmit.
// - Own address plus write bit sets the flag and posts a status code.
// - Addressed for write after lost arbitration reports 0x68 own or 0x78 general call.
// - Acknowledge enable cleared mid-transfer gives NACK after the next byte.
// - With acknowledge enable zero the own address is ignored; bus still tracked.
// - In deep sleep with ack enable, address match still acks and wakes.
// - After wake match, SCL held low until software clears the flag.
// - Data register need not hold the last bus byte after wake.
// - Writing one to the flag clears it and starts the selected action.
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module tsr_core
   import tsr_pkg::*;
(
   input  wire logic                  MCLK,
   input  wire logic                  RSTN,
   input  wire tsr_pkg::tsr_apb_req_t APB_REQ,
   output      tsr_pkg::tsr_apb_rsp_t APB_RSP,
   input  wire logic                  SCL_I,
   output      logic                  SCL_O,
   output      logic                  SCL_OE,
   input  wire logic                  SDA_I,
   output      logic                  SDA_O,
   output      logic                  SDA_OE,
   input  wire logic                  SLEEP_DEEP,
   output      logic                  WAKE_REQ
);
   import tsr_pkg::*;

   logic [1:0]  scl_sy_q;
   logic [1:0]  sda_sy_q;
   logic        scl_p_q;
   logic        sda_p_q;
   logic        scl;
   logic        sda;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_det;
   logic        stop_det;
   logic        busy_q;
   logic [3:0]  bcnt_q;
   logic [7:0]  sh_q;
   logic        first_q;
   logic        ack_hi_q;
   logic        slot_q;
   logic        byte_end;
   logic [7:0]  ctrl_q;
   logic [7:0]  stat_q;
   logic [7:0]  data_q;
   logic [7:0]  addr_q;
   logic        irq_q;
   logic        irq_clr;
   logic        wr_ok;
   logic        rd_go;
   logic        own_hit;
   logic        gc_hit;
   tsr_state_t  state_q;
   logic [1:0]  ph_q;
   logic [9:0]  tmr_q;
   logic [3:0]  mbit_q;
   logic [7:0]  msh_q;
   logic        mrx_q;
   logic        maddr_q;
   logic        mread_q;
   logic        mown_q;
   logic        mack_q;
   logic        scl_drv_q;
   logic        sda_drv_q;
   logic        arb_q;
   logic        s_addr_q;
   logic        s_gc_q;
   logic        s_tx_q;
   logic        s_ack_q;
   logic        s_nack_q;
   logic        ev_q;
   logic [7:0]  code_q;
   logic        cap_q;
   logic        sto_clr_q;
   logic        wake_q;
   logic        bit_val;
   logic        tmr_zero;

   // Logic reads the second stage and its delayed copy, never the first stage
   always_ff @(posedge MCLK)
   begin
      if (!RSTN)
      begin
         scl_sy_q <= 2'h3;
         sda_sy_q <= 2'h3;
         scl_p_q  <= 1'b1;
         sda_p_q  <= 1'b1;
      end
      else
      begin
         scl_sy_q <= {scl_sy_q[0], SCL_I};
         sda_sy_q <= {sda_sy_q[0], SDA_I};
         scl_p_q  <= scl_sy_q[1];
         sda_p_q  <= sda_sy_q[1];
      end
   end

   assign scl       = scl_sy_q[1];
   assign sda       = sda_sy_q[1];
   assign scl_rise  = scl & ~scl_p_q;
   assign scl_fall  = ~scl & scl_p_q;
   assign start_det = scl & scl_p_q & sda_p_q & ~sda;
   assign stop_det  = scl & scl_p_q & ~sda_p_q & sda;
   assign byte_end  = scl_fall & ack_hi_q;
   assign own_hit   = sh_q[7:1] == addr_q[7:1];
   assign gc_hit    = (sh_q[7:1] == 7'h00) & addr_q[0];
   assign tmr_zero  = tmr_q == 10'h000;

   // Bus monitor: tracks every byte on the wire, ours or not
   always_ff @(posedge MCLK)
   begin
      if (!RSTN)
      begin
         busy_q   <= 1'b0;
         bcnt_q   <= 4'h0;
         sh_q     <= 8'h00;
         first_q  <= 1'b0;
         ack_hi_q <= 1'b0;
         slot_q   <= 1'b0;
      end
      else if (start_det)
      begin
         busy_q   <= 1'b1;
         bcnt_q   <= 4'h0;
         first_q  <= 1'b1;
         ack_hi_q <= 1'b0;
         slot_q   <= 1'b0;
      end
      else if (stop_det)
      begin
         busy_q   <= 1'b0;
         bcnt_q   <= 4'h0;
         first_q  <= 1'b0;
         ack_hi_q <= 1'b0;
         slot_q   <= 1'b0;
      end
      else
      begin
         if (scl_rise && bcnt_q == 4'h8)
         begin
            bcnt_q   <= 4'h0;
            ack_hi_q <= 1'b1;
         end
         else if (scl_rise)
         begin
            sh_q   <= {sh_q[6:0], sda};
            bcnt_q <= bcnt_q + 4'h1;
         end
         if (scl_fall)
         begin
            ack_hi_q <= 1'b0;
            slot_q   <= bcnt_q == 4'h8;
            if (ack_hi_q)
               first_q <= 1'b0;
         end
      end
   end

   // Bit value the master puts on SDA for the current bit
   always_comb
   begin
      if (mbit_q == 4'h8)
         bit_val = mrx_q ? mack_q : 1'b1;
      else
         bit_val = mrx_q ? 1'b1 : msh_q[3'd7 - mbit_q[2:0]];
   end

   // Protocol engine, master and slave
   always_ff @(posedge MCLK)
   begin
      if (!RSTN || !ctrl_q[CB_EN])
      begin
         state_q   <= ST_IDLE;
         ph_q      <= 2'h0;
         tmr_q     <= 10'h000;
         mbit_q    <= 4'h0;
         msh_q     <= 8'h00;
         mrx_q     <= 1'b0;
         maddr_q   <= 1'b0;
         mread_q   <= 1'b0;
         mown_q    <= 1'b0;
         mack_q    <= 1'b1;
         scl_drv_q <= 1'b0;
         sda_drv_q <= 1'b0;
         arb_q     <= 1'b0;
         s_addr_q  <= 1'b0;
         s_gc_q    <= 1'b0;
         s_tx_q    <= 1'b0;
         s_ack_q   <= 1'b0;
         s_nack_q  <= 1'b0;
         ev_q      <= 1'b0;
         code_q    <= RST_STAT;
         cap_q     <= 1'b0;
         sto_clr_q <= 1'b0;
         wake_q    <= 1'b0;
      end
      else
      begin
         ev_q      <= 1'b0;
         cap_q     <= 1'b0;
         sto_clr_q <= 1'b0;
         if (!tmr_zero)
            tmr_q <= tmr_q - 10'h001;
         if (stop_det && state_q != ST_HOLD)
            s_addr_q <= 1'b0;
         // Ack decision latched as the ninth clock's low phase begins
         if (scl_fall && bcnt_q == 4'h8 && state_q == ST_IDLE)
         begin
            if (first_q)
               s_ack_q <= ctrl_q[CB_ACK] & (own_hit | gc_hit);
            else
               s_ack_q <= s_addr_q & ~s_tx_q & ctrl_q[CB_ACK];
         end
         case (state_q)
            ST_IDLE:
            begin
               if (byte_end && first_q && s_ack_q)
               begin
                  s_addr_q  <= 1'b1;
                  s_gc_q    <= gc_hit;
                  s_tx_q    <= sh_q[0];
                  s_nack_q  <= 1'b0;
                  code_q    <= sh_q[0] ? (arb_q ? SC_SR_ARB : SC_SR_OWN)
                             : gc_hit ? (arb_q ? SC_GC_ARB : SC_GC)
                             : (arb_q ? SC_SW_ARB : SC_SW_OWN);
                  wake_q    <= SLEEP_DEEP;
                  ev_q      <= 1'b1;
                  scl_drv_q <= 1'b1;
                  arb_q     <= 1'b0;
                  state_q   <= ST_HOLD;
               end
               else if (byte_end && arb_q)
               begin
                  code_q  <= SC_ARB;
                  ev_q    <= 1'b1;
                  arb_q   <= 1'b0;
                  state_q <= ST_HOLD;
               end
               else if (byte_end && s_addr_q && !s_tx_q && !SLEEP_DEEP)
               begin
                  // No capture in deep sleep, so the data register may be stale
                  cap_q     <= 1'b1;
                  s_nack_q  <= ~s_ack_q;
                  code_q    <= s_gc_q ? (s_ack_q ? SC_GD_ACK : SC_GD_NACK)
                             : (s_ack_q ? SC_SD_ACK : SC_SD_NACK);
                  ev_q      <= 1'b1;
                  scl_drv_q <= 1'b1;
                  state_q   <= ST_HOLD;
               end
               // Own START only from a quiet bus, so an address aimed at us is never missed
               else if (ctrl_q[CB_STA] && !busy_q && !arb_q && !s_addr_q && !irq_q && !ev_q)
               begin
                  tmr_q   <= 10'h000;
                  ph_q    <= 2'h0;
                  state_q <= ST_START;
               end
            end
            ST_HOLD:
            begin
               if (!irq_q && !ev_q)
               begin
                  wake_q <= 1'b0;
                  ph_q   <= 2'h0;
                  tmr_q  <= LOW_CYC;
                  if (mown_q && ctrl_q[CB_STO])
                  begin
                     sda_drv_q <= 1'b1;
                     state_q   <= ST_STOP;
                  end
                  else if (ctrl_q[CB_STA] && (mown_q || !s_addr_q || s_nack_q))
                  begin
                     s_addr_q <= 1'b0;
                     state_q  <= ST_START;
                  end
                  else if (mown_q && (code_q == SC_START || code_q == SC_RSTART || !mread_q))
                  begin
                     msh_q     <= data_q;
                     maddr_q   <= code_q == SC_START || code_q == SC_RSTART;
                     if (code_q == SC_START || code_q == SC_RSTART)
                        mread_q <= data_q[0];
                     mrx_q     <= 1'b0;
                     mbit_q    <= 4'h0;
                     sda_drv_q <= ~data_q[7];
                     state_q   <= ST_BIT;
                  end
                  else if (mown_q)
                  begin
                     mack_q    <= ~ctrl_q[CB_ACK];
                     mrx_q     <= 1'b1;
                     maddr_q   <= 1'b0;
                     mbit_q    <= 4'h0;
                     sda_drv_q <= 1'b0;
                     state_q   <= ST_BIT;
                  end
                  else
                  begin
                     if (s_nack_q)
                        s_addr_q <= 1'b0;
                     scl_drv_q <= 1'b0;
                     state_q   <= ST_IDLE;
                  end
               end
            end
            ST_START:
            begin
               case (ph_q)
                  2'h0:
                  begin
                     sda_drv_q <= 1'b0;
                     if (tmr_zero)
                     begin
                        scl_drv_q <= 1'b0;
                        ph_q      <= 2'h1;
                     end
                  end
                  2'h1:
                  begin
                     // Waits for a free bus unless we already own it
                     if (!(scl && sda && (mown_q || !busy_q)))
                        tmr_q <= HIGH_CYC;
                     else if (tmr_zero)
                     begin
                        sda_drv_q <= 1'b1;
                        tmr_q     <= HIGH_CYC;
                        ph_q      <= 2'h2;
                     end
                  end
                  default:
                  begin
                     if (tmr_zero)
                     begin
                        scl_drv_q <= 1'b1;
                        mown_q    <= 1'b1;
                        code_q    <= mown_q ? SC_RSTART : SC_START;
                        ev_q      <= 1'b1;
                        state_q   <= ST_HOLD;
                     end
                  end
               endcase
            end
            ST_BIT:
            begin
               if (ph_q == 2'h0)
               begin
                  if (tmr_zero)
                  begin
                     scl_drv_q <= 1'b0;
                     tmr_q     <= HIGH_CYC;
                     ph_q      <= 2'h1;
                  end
               end
               else if (!scl)
                  tmr_q <= HIGH_CYC;
               else if (bit_val && !sda && (mrx_q ? mbit_q == 4'h8 : mbit_q != 4'h8))
               begin
                  // Someone else holds SDA low: hand over to the monitor
                  sda_drv_q <= 1'b0;
                  mown_q    <= 1'b0;
                  arb_q     <= 1'b1;
                  state_q   <= ST_IDLE;
               end
               else if (tmr_zero)
               begin
                  scl_drv_q <= 1'b1;
                  tmr_q     <= LOW_CYC;
                  ph_q      <= 2'h0;
                  if (mbit_q == 4'h8)
                  begin
                     sda_drv_q <= 1'b0;
                     ev_q      <= 1'b1;
                     cap_q     <= mrx_q;
                     state_q   <= ST_HOLD;
                     if (mrx_q)
                        code_q <= mack_q ? SC_MR_NACK : SC_MR_ACK;
                     else if (maddr_q)
                        code_q <= mread_q ? (sda ? SC_AR_NACK : SC_AR_ACK)
                                : (sda ? SC_AW_NACK : SC_AW_ACK);
                     else
                        code_q <= sda ? SC_DT_NACK : SC_DT_ACK;
                  end
                  else
                  begin
                     mbit_q    <= mbit_q + 4'h1;
                     sda_drv_q <= (mbit_q == 4'h7) ? ~(mrx_q ? mack_q : 1'b1)
                                : ~(mrx_q ? 1'b1 : msh_q[3'd6 - mbit_q[2:0]]);
                  end
               end
            end
            ST_STOP:
            begin
               if (tmr_zero && ph_q == 2'h0)
               begin
                  scl_drv_q <= 1'b0;
                  tmr_q     <= HIGH_CYC;
                  ph_q      <= 2'h1;
               end
               else if (ph_q == 2'h1 && !scl)
                  tmr_q <= HIGH_CYC;
               else if (tmr_zero && ph_q == 2'h1)
               begin
                  sda_drv_q <= 1'b0;
                  tmr_q     <= LOW_CYC;
                  ph_q      <= 2'h2;
               end
               else if (tmr_zero)
               begin
                  mown_q    <= 1'b0;
                  sto_clr_q <= 1'b1;
                  ph_q      <= 2'h0;
                  state_q   <= ctrl_q[CB_STA] ? ST_START : ST_IDLE;
               end
            end
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end

   // Open-drain pads: outputs are constant low, enables pull the wire
   always_ff @(posedge MCLK)
   begin
      if (!RSTN)
      begin
         SCL_O    <= 1'b0;
         SDA_O    <= 1'b0;
         SCL_OE   <= 1'b0;
         SDA_OE   <= 1'b0;
         WAKE_REQ <= 1'b0;
      end
      else
      begin
         SCL_O    <= 1'b0;
         SDA_O    <= 1'b0;
         SCL_OE   <= scl_drv_q;
         SDA_OE   <= sda_drv_q | (slot_q & s_ack_q & state_q == ST_IDLE);
         WAKE_REQ <= wake_q;
      end
   end

   // APB slave: one wait state, so every answer is registered
   assign rd_go   = APB_REQ.psel & APB_REQ.penable & ~APB_RSP.pready;
   assign wr_ok   = APB_REQ.psel & APB_REQ.penable & APB_RSP.pready & APB_REQ.pwrite;
   assign irq_clr = wr_ok & (APB_REQ.paddr == OFS_CTRL) & APB_REQ.pwdata[CB_IRQ];

   always_ff @(posedge MCLK)
   begin
      if (!RSTN)
         APB_RSP <= '0;
      else
      begin
         APB_RSP.pready  <= rd_go;
         APB_RSP.pslverr <= rd_go & (APB_REQ.paddr != OFS_CTRL) & (APB_REQ.paddr != OFS_STAT)
                            & (APB_REQ.paddr != OFS_DATA) & (APB_REQ.paddr != OFS_ADDR);
         if (rd_go)
         begin
            case (APB_REQ.paddr)
               OFS_CTRL: APB_RSP.prdata <= {24'h000000, irq_q, ctrl_q[6:0]};
               OFS_STAT: APB_RSP.prdata <= {24'h000000, stat_q};
               OFS_DATA: APB_RSP.prdata <= {24'h000000, data_q};
               OFS_ADDR: APB_RSP.prdata <= {24'h000000, addr_q};
               default:  APB_RSP.prdata <= 32'h00000000;
            endcase
         end
      end
   end

   // Flag: a hardware event in the clear cycle wins
   always_ff @(posedge MCLK)
   begin
      if (!RSTN)
         irq_q <= 1'b0;
      else if (ev_q)
         irq_q <= 1'b1;
      else if (irq_clr)
         irq_q <= 1'b0;
   end

   always_ff @(posedge MCLK)
   begin
      if (!RSTN)
      begin
         ctrl_q <= RST_CTRL;
         stat_q <= RST_STAT;
         addr_q <= RST_ADDR;
         data_q <= RST_DATA;
      end
      else
      begin
         if (wr_ok && APB_REQ.paddr == OFS_CTRL)
         begin
            ctrl_q[CB_ACK] <= APB_REQ.pwdata[CB_ACK];
            ctrl_q[CB_STA] <= APB_REQ.pwdata[CB_STA];
            ctrl_q[CB_STO] <= APB_REQ.pwdata[CB_STO];
            ctrl_q[CB_EN]  <= APB_REQ.pwdata[CB_EN];
            ctrl_q[CB_IE]  <= APB_REQ.pwdata[CB_IE];
         end
         else if (sto_clr_q)
            ctrl_q[CB_STO] <= 1'b0;
         if (wr_ok && APB_REQ.paddr == OFS_STAT)
            stat_q[SB_PRE_MSB:0] <= APB_REQ.pwdata[SB_PRE_MSB:0];
         if (ev_q)
            stat_q[7:SB_CODE_LSB] <= code_q[7:SB_CODE_LSB];
         if (wr_ok && APB_REQ.paddr == OFS_ADDR)
            addr_q <= APB_REQ.pwdata[7:0];
         // Loading data while the engine runs is refused and flagged
         if (cap_q)
            data_q <= sh_q;
         else if (wr_ok && APB_REQ.paddr == OFS_DATA && irq_q)
         begin
            data_q       <= APB_REQ.pwdata[7:0];
            ctrl_q[CB_WC] <= 1'b0;
         end
         else if (wr_ok && APB_REQ.paddr == OFS_DATA)
            ctrl_q[CB_WC] <= 1'b1;
      end
   end

endmodule : tsr_core

/* File: sim/tsr_chk.sv */
// Port checker for the two-wire receive engine.
// Bound to tsr_core; one MCLK domain.
`timescale 1ns/1ps
module tsr_chk
   import tsr_pkg::*;
(
   input wire logic                  MCLK,
   input wire logic                  RSTN,
   input wire tsr_pkg::tsr_apb_req_t APB_REQ,
   input wire tsr_pkg::tsr_apb_rsp_t APB_RSP,
   input wire logic                  SCL_I,
   input wire logic                  SCL_O,
   input wire logic                  SCL_OE,
   input wire logic                  SDA_I,
   input wire logic                  SDA_O,
   input wire logic                  SDA_OE,
   input wire logic                  SLEEP_DEEP,
   input wire logic                  WAKE_REQ
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RSTN);
   logic acc;
   assign acc = APB_REQ.psel && APB_REQ.penable;
   sequence acc_first;
      acc && !$past(acc);
   endsequence
   sequence ctrl_off;
      APB_RSP.pready && APB_REQ.pwrite && APB_REQ.paddr == OFS_CTRL && !APB_REQ.pwdata[CB_EN];
   endsequence
   ack_time_a: assert property (acc_first |=> APB_RSP.pready) else $error("pready late");
   rsp_pulse_a: assert property (APB_RSP.pready |-> acc ##1 !APB_RSP.pready) else $error("pready pulse");
   err_map_a: assert property (APB_RSP.pready |-> APB_RSP.pslverr == (APB_REQ.paddr > OFS_ADDR
      || APB_REQ.paddr[1:0] != 2'h0)) else $error("pslverr wrong");
   rd_upper_a: assert property (APB_RSP.pready |-> APB_RSP.prdata[31:8] == 24'h0) else $error("prdata high");
   od_drive_a: assert property (!SCL_O && !SDA_O) else $error("pin driven high");
   dis_rel_a: assert property (ctrl_off |-> ##[1:3] !SCL_OE && !SDA_OE) else $error("no release");
   wake_sleep_a: assert property ($rose(WAKE_REQ) |-> SLEEP_DEEP) else $error("wake awake");
   wake_hold_a: assert property ($rose(WAKE_REQ) |-> ##[0:60] SCL_OE) else $error("no stretch");
endmodule : tsr_chk
bind tsr_core tsr_chk chk_i (.MCLK(MCLK), .RSTN(RSTN), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .SCL_I(SCL_I),
   .SCL_O(SCL_O), .SCL_OE(SCL_OE), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE), .SLEEP_DEEP(SLEEP_DEEP),
   .WAKE_REQ(WAKE_REQ));

/* File: sim/tsr_mst_model.sv */
// Model bus master and answering slave; both wires pulled up.
// 80 ns bits, waits out any SCL stretch.
`timescale 1ns/1ps
module tsr_mst_model (
   input  wire logic scl_oe,
   input  wire logic sda_oe,
   output wire logic scl,
   output wire logic sda
);
   logic scl_m = 1'b1;
   logic sda_m = 1'b1;
   assign scl = scl_m && !scl_oe;
   assign sda = sda_m && !sda_oe;
   task automatic bit_io(input logic b, output logic s);
      sda_m = b;
      #20;
      scl_m = 1'b1;
      wait (scl === 1'b1);
      #40;
      s = sda;
      scl_m = 1'b0;
      #20;
   endtask : bit_io
   task automatic send(input logic st, input logic [7:0] v, output logic ack);
      logic s;
      if (st)
      begin
         sda_m = 1'b0;
         #40;
         scl_m = 1'b0;
         #20;
      end
      for (int i = 7; i >= 0; i--)
         bit_io(v[i], s);
      bit_io(1'b1, ack);
   endtask : send
   task automatic stop;
      sda_m = 1'b0;
      #20;
      scl_m = 1'b1;
      wait (scl === 1'b1);
      #20;
      sda_m = 1'b1;
      #40;
   endtask : stop
   // Slave side: nine bits, each set while SCL is low
   task automatic answer(input logic [8:0] v);
      for (int i = 8; i >= 0; i--)
      begin
         wait (scl === 1'b0);
         #10;
         sda_m = v[i];
         wait (scl === 1'b1);
      end
      wait (scl === 1'b0);
      #10;
      sda_m = 1'b1;
   endtask : answer
endmodule : tsr_mst_model

/* File: sim/tb_top.sv */
// Bench: APB traffic plus model-master frames.
// Assumes the checker is bound to tsr_core.
`timescale 1ns/1ps
module tb_top;
   import tsr_pkg::*;
   logic         mclk = 1'b0;
   logic         rstn = 1'b0;
   logic         sleep = 1'b0;
   tsr_apb_req_t req = '0;
   tsr_apb_rsp_t rsp;
   logic         scl_oe, sda_oe, wake, scl, sda, a;
   logic [7:0]   d;
   logic [7:0]   exp_q[$];
   int           fail_count = 0;
   int           n_tests = 0;
   tsr_core uut (.MCLK(mclk), .RSTN(rstn), .APB_REQ(req), .APB_RSP(rsp), .SCL_I(scl), .SCL_O(), .SCL_OE(scl_oe),
      .SDA_I(sda), .SDA_O(), .SDA_OE(sda_oe), .SLEEP_DEEP(sleep), .WAKE_REQ(wake));
   tsr_mst_model m (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl), .sda(sda));
   initial
      forever #2.5 mclk = ~mclk;
   task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
      n_tests++;
      if (s !== e)
      begin
         fail_count++;
         $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : report_and_stop
   task automatic apb(input logic w, input logic [7:0] ad, input logic [7:0] wd);
      @(posedge mclk);
      req <= '{1'b1, 1'b0, w, ad, {24'h0, wd}};
      @(posedge mclk);
      req.penable <= 1'b1;
      do
         @(posedge mclk);
      while (rsp.pready !== 1'b1);
      req <= '0;
   endtask : apb
   task automatic rd(input logic [7:0] ad, input logic [7:0] e);
      exp_q.push_back(e);
      apb(1'b0, ad, 8'h00);
   endtask : rd
   // Waits for the stretch that marks a posted event
   task automatic xfer(input logic st, input logic [7:0] v, input logic e);
      m.send(st, v, a);
      chk("ack", {7'h0, a}, {7'h0, e});
      for (int i = 0; i < 200 && scl_oe !== 1'b1; i++)
         @(posedge mclk);
   endtask : xfer
   always @(posedge mclk)
      if (rsp.pready === 1'b1 && req.pwrite === 1'b0)
         chk("prdata", rsp.prdata[7:0], exp_q.pop_front());
   initial
   begin
      #400000;
      fail_count++;
      report_and_stop();
   end
   initial
   begin
      void'($urandom(68942));
      d = 8'($urandom);
      repeat (12) @(posedge mclk);
      rstn <= 1'b1;
      rd(OFS_CTRL, RST_CTRL);
      rd(OFS_STAT, RST_STAT);
      rd(OFS_DATA, RST_DATA);
      rd(OFS_ADDR, RST_ADDR);
      rd(8'h10, 8'h00);
      apb(1'b1, OFS_STAT, d);
      rd(OFS_STAT, {RST_STAT[7:2], d[1:0]});
      apb(1'b1, OFS_STAT, 8'h00);
      apb(1'b1, OFS_ADDR, 8'h55);
      apb(1'b1, OFS_CTRL, 8'h04);
      xfer(1'b1, 8'h54, 1'b1);
      m.stop();
      apb(1'b1, OFS_CTRL, 8'h44);
      xfer(1'b1, 8'h54, 1'b0);
      rd(OFS_STAT, SC_SW_OWN);
      rd(OFS_CTRL, 8'hc4);
      apb(1'b1, OFS_CTRL, 8'hc4);
      xfer(1'b0, d, 1'b0);
      rd(OFS_STAT, SC_SD_ACK);
      rd(OFS_DATA, d);
      apb(1'b1, OFS_CTRL, 8'h84);
      xfer(1'b0, ~d, 1'b1);
      rd(OFS_STAT, SC_SD_NACK);
      apb(1'b1, OFS_CTRL, 8'hc4);
      m.stop();
      xfer(1'b1, 8'h00, 1'b0);
      rd(OFS_STAT, SC_GC);
      apb(1'b1, OFS_CTRL, 8'hc4);
      m.stop();
      @(posedge mclk) sleep <= 1'b1;
      xfer(1'b1, 8'h54, 1'b0);
      chk("wake", {7'h0, wake}, 8'h01);
      @(posedge mclk) sleep <= 1'b0;
      apb(1'b1, OFS_CTRL, 8'hc4);
      m.stop();
      chk("wake", {7'h0, wake}, 8'h00);
      apb(1'b1, OFS_DATA, d);
      rd(OFS_CTRL, 8'h4c);
      rd(OFS_DATA, ~d);
      apb(1'b1, OFS_CTRL, 8'ha4);
      wait (scl === 1'b0);
      rd(OFS_STAT, SC_START);
      apb(1'b1, OFS_DATA, {d[7:1], 1'b1});
      apb(1'b1, OFS_CTRL, 8'h84);
      m.answer(9'h1fe);
      rd(OFS_STAT, SC_AR_ACK);
      apb(1'b1, OFS_CTRL, 8'h84);
      m.answer({d ^ 8'h5a, 1'b1});
      rd(OFS_STAT, SC_MR_NACK);
      rd(OFS_DATA, d ^ 8'h5a);
      apb(1'b1, OFS_CTRL, 8'h94);
      repeat (3000) @(posedge mclk);
      rd(OFS_CTRL, 8'h04);
      apb(1'b1, OFS_CTRL, 8'h00);
      report_and_stop();
   end
endmodule : tb_top
